// [dv/rail_load_model.sv]
// behavioural storage capacitor and load on the far side of the rails
module rail_load_model (
    input  wire logic       clock,
    input  wire logic       charge_en,
    input  wire logic       drain,
    input  wire logic [3:0] residual,
    output logic      [3:0] cap
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // capacitor level
    // ****************************************
    initial cap = 4'h0;
    // slow ramp so the charge end always lands on a real comparator step
    always @(posedge clock) begin
        if (charge_en && cap != 4'hf) begin
            cap <= cap + 4'h1;
        end else if (drain) begin
            cap <= residual;
        end
    end
endmodule // rail_load_model

// [dv/rail_switch_charge_optimizer_asserts.sv]
// port checker for the rail switch and charge optimizer
module rail_port_checker
    import rail_pkg::*;
(
    input wire logic               CLOCK,
    input wire logic               RST_N,
    input wire logic               CE,
    input wire logic               ON_DEMAND,
    input wire logic               VSET_WR,
    input wire logic [LEVEL_W-1:0] VSET_DATA,
    input wire logic               CEIL_SEL,
    input wire logic [1:0]         STATE,
    input wire logic               PERM_FROM_BATTERY,
    input wire logic               PERM_FROM_HC,
    input wire logic               HC_FROM_BATTERY,
    input wire logic               HC_FROM_REG,
    input wire logic               HC_HIZ,
    input wire logic [LEVEL_W-1:0] REG_LEVEL,
    input wire logic [LEVEL_W-1:0] CHARGE_TARGET,
    input wire logic [LEVEL_W-1:0] VSET,
    input wire logic               HIZ_SEL
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    property p_perm; STATE != ST_ACTIVE |-> PERM_FROM_BATTERY && !PERM_FROM_HC; endproperty
    a_perm: assert property (p_perm) else $error("permanent rail off battery");
    property p_rails; STATE == ST_ACTIVE |-> HC_FROM_REG && PERM_FROM_HC && !HC_FROM_BATTERY; endproperty
    a_rails: assert property (p_rails) else $error("active rails wrong");
    // two cycles allow for a one cycle lag behind the select bit
    property p_hcbat; (STATE != ST_ACTIVE && !HIZ_SEL) [*2] |-> HC_FROM_BATTERY && !HC_HIZ; endproperty
    a_hcbat: assert property (p_hcbat) else $error("high-current rail off battery");
    property p_hiz; (STATE != ST_ACTIVE && HIZ_SEL) [*2] |-> HC_HIZ && !HC_FROM_BATTERY; endproperty
    a_hiz: assert property (p_hiz) else $error("high-current rail driven");
    property p_vset; VSET_WR && CE |=> VSET == $past(VSET_DATA) ##1 REG_LEVEL == $past(VSET_DATA, 2); endproperty
    a_vset: assert property (p_vset) else $error("output level not applied");
    property p_hold; STATE == ST_ACTIVE && ON_DEMAND && VSET_WR |=> STATE == ST_ACTIVE; endproperty
    a_hold: assert property (p_hold) else $error("level write left active");
    property p_ceil; CHARGE_TARGET <= ((CEIL_SEL || $past(CEIL_SEL)) ? CEIL_HIGH : CEIL_LOW); endproperty
    a_ceil: assert property (p_ceil) else $error("charge target above ceiling");
    property p_start; STATE == ST_STANDBY && ON_DEMAND && CE |=> STATE == ST_CHARGE; endproperty
    a_start: assert property (p_start) else $error("demand did not start charge");
    c_active_vset: cover property (STATE == ST_ACTIVE && VSET_WR);
    c_hiz_charge: cover property (HIZ_SEL && STATE == ST_CHARGE);
    c_low_ceiling: cover property (!CEIL_SEL && STATE == ST_CHARGE);
endmodule // rail_port_checker
bind rail_switch_charge_optimizer rail_port_checker chk (
    .CLOCK, .RST_N, .CE, .ON_DEMAND, .VSET_WR, .VSET_DATA, .CEIL_SEL, .STATE,
    .PERM_FROM_BATTERY, .PERM_FROM_HC, .HC_FROM_BATTERY, .HC_FROM_REG, .HC_HIZ,
    .REG_LEVEL, .CHARGE_TARGET, .VSET, .HIZ_SEL
);

// [dv/rail_switch_charge_optimizer_test.sv]
// self-checking bench for the rail switch and charge optimizer
module rail_switch_charge_optimizer_test
    import rail_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // stimulus, target model and scoreboard
    // ****************************************
    logic       CLOCK = 1'b0;
    logic       RST_N = 1'b0;
    logic       ON_DEMAND = 1'b0;
    logic       START_PIN = 1'b0;
    logic       CEIL_SEL = 1'b1;
    logic [5:0] strb = 6'h00;
    logic [5:0] wdat = 6'h00;
    logic [3:0] residual = 4'h0;
    wire  [3:0] CAP_LEVEL;
    logic [1:0] STATE, MARGIN, marg = 2'h3, prev = 2'h0;
    logic       PERM_FROM_BATTERY, PERM_FROM_HC, HC_FROM_BATTERY, HC_FROM_REG, HC_HIZ;
    logic       CHARGE_EN, HIZ_SEL;
    logic [3:0] REG_LEVEL, CHARGE_TARGET, VSET, fix = 4'hf;
    logic [5:0] PROF, sel = 6'h01;
    logic [3:0] tgt [64] = '{default: 4'hf};
    logic [3:0] exp_q [$];
    int         seed = 32'h7334;
    int         miscompares = 0;
    int         compares = 0;
    rail_switch_charge_optimizer dut (
        .CLOCK, .RST_N, .CE(1'b1), .ON_DEMAND, .FORCE_ACTIVE(1'b0), .START_PIN, .CAP_LEVEL,
        .VSET_WR(strb[0]), .VSET_DATA(wdat[3:0]), .HIZ_WR(strb[1]), .HIZ_DATA(wdat[0]),
        .PROF_WR(strb[2]), .PROF_DATA(wdat), .PROF_RESTART(strb[5]), .MARGIN_WR(strb[3]),
        .MARGIN_DATA(wdat[1:0]), .FIX_WR(strb[4]), .FIX_DATA(wdat[3:0]), .CEIL_SEL, .STATE,
        .PERM_FROM_BATTERY, .PERM_FROM_HC, .HC_FROM_BATTERY, .HC_FROM_REG, .HC_HIZ,
        .REG_LEVEL, .CHARGE_EN, .CHARGE_TARGET, .VSET, .HIZ_SEL, .PROF, .MARGIN
    );
    rail_load_model load (.clock(CLOCK), .charge_en(CHARGE_EN), .drain(HC_FROM_REG),
        .residual(residual), .cap(CAP_LEVEL));
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    task automatic tick(int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check_cfg(logic [5:0] got, logic [5:0] want);
        compares++;
        if (got !== want) begin
            miscompares++;
            $display("wrong value at %0t: field %h, expected %h", $time, got, want);
        end
    endtask
    task automatic check_target();
        logic [3:0] want;
        want = exp_q.size() > 0 ? exp_q.pop_front() : 4'hx;
        compares++;
        if (CHARGE_TARGET !== want) begin
            miscompares++;
            $display("wrong value at %0t: target %h, expected %h", $time, CHARGE_TARGET, want);
        end
    endtask
    // strobes are one cycle wide; bench copy of profile, margin and fixed level follows their writes
    task automatic wr(int f, logic [5:0] d);
        strb <= 6'h01 << f;
        wdat <= d;
        if (f == 2) sel = d;
        if (f == 3) marg = d[1:0];
        if (f == 4) fix = d[3:0];
        if (f == 5) tgt[sel] = CEIL_HIGH;
        tick(1);
        strb <= 6'h00;
        tick(1);
    endtask
    function automatic logic [3:0] want_tgt();
        logic [3:0] c;
        logic [3:0] t;
        c = CEIL_SEL ? CEIL_HIGH : CEIL_LOW;
        t = sel == PROF_OFF ? fix : tgt[sel];
        return t > c ? c : t;
    endfunction
    task automatic run(logic [3:0] res, bit pin);
        int i;
        int d;
        int n;
        logic [3:0] v;
        exp_q.push_back(want_tgt());
        residual <= res;
        START_PIN <= pin;
        ON_DEMAND <= !pin;
        for (i = 0; i < 90 && STATE !== ST_ACTIVE; i++) @(negedge CLOCK);
        tick(4);
        v = 4'($random(seed));
        if (!pin) wr(0, {2'h0, v});
        @(negedge CLOCK);
        check_cfg(STATE, ST_ACTIVE);
        if (!pin) check_cfg(VSET, v);
        tick(1);
        START_PIN <= 1'b0;
        ON_DEMAND <= 1'b0;
        tick(8);
        d = int'(marg) - int'(res);
        n = int'(tgt[sel]) + (d >= int'(DEEP_DEFICIT) ? 2 : 1);
        if (sel != PROF_OFF && d < 0 && tgt[sel] != 4'h0) tgt[sel] = tgt[sel] - 4'h1;
        if (sel != PROF_OFF && d > 0) tgt[sel] = n > 15 ? 4'hf : 4'(n);
    endtask
    // the target shown on entry to charge is the level learned so far, or the fixed level for profile zero
    always @(negedge CLOCK) begin
        if (STATE === ST_CHARGE && prev !== ST_CHARGE) check_target();
        prev <= STATE;
    end
    initial begin
        logic [31:0] r;
        tick(2);
        RST_N <= 1'b1;
        @(negedge CLOCK);
        check_cfg(VSET, VSET_RESET);
        check_cfg(HIZ_SEL, 1'b0);
        check_cfg(PROF, 6'h01);
        check_cfg(MARGIN, 6'h03);
        tick(1);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            wr(3, {4'h0, r[1:0]});
            run({1'b0, r[6:4]}, k == 3);
        end
        wr(5, 6'h00);
        run(4'h7, 1'b0);
        wr(2, 6'h02);
        run(4'h1, 1'b0);
        wr(2, 6'h01);
        run(4'h3, 1'b0);
        wr(1, 6'h01);
        @(negedge CLOCK);
        check_cfg(HC_HIZ, 1'b1);
        tick(1);
        run(4'h2, 1'b0);
        wr(1, 6'h00);
        wr(4, 6'h09);
        wr(2, 6'h00);
        run(4'h5, 1'b0);
        CEIL_SEL <= 1'b0;
        wr(4, 6'h0f);
        run(4'h2, 1'b0);
        complete_run();
    end
    // a cycle takes well under a hundred clocks
    initial begin
        #50000;
        miscompares++;
        complete_run();
    end
endmodule // rail_switch_charge_optimizer_test

// [rtl/profile_store.sv]
// hidden per-profile storage of learned capacitor targets
module profile_store
    import rail_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic [PROF_W-1:0]  rd_prof,
    output logic      [LEVEL_W-1:0] rd_level,
    output logic                    rd_valid,
    input  wire logic               wr_en,
    input  wire logic [PROF_W-1:0]  wr_prof,
    input  wire logic [LEVEL_W-1:0] wr_level,
    input  wire logic               clr_en,
    input  wire logic [PROF_W-1:0]  clr_prof
);

    // ******************************************************
    // storage
    // ******************************************************
    logic [LEVEL_W-1:0] level_mem [PROF_COUNT];
    logic [PROF_COUNT-1:0] valid;

    // data array needs no reset: an invalid entry is never used
    always_ff @(posedge clock) begin
        if (ce && wr_en) begin
            level_mem[wr_prof] <= wr_level;
        end
    end

    // valid bits cleared at power-on so every profile restarts learning
    genvar i;
    generate
        for (i = 0; i < PROF_COUNT; i++) begin : g_valid
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    valid[i] <= 1'b0;
                end else if (ce) begin
                    if (wr_en && wr_prof == PROF_W'(i)) begin
                        valid[i] <= 1'b1;
                    end else if (clr_en && clr_prof == PROF_W'(i)) begin
                        valid[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign rd_level = level_mem[rd_prof];
    assign rd_valid = valid[rd_prof];

endmodule // profile_store

// [rtl/rail_pkg.sv]
// shared constants and types for the rail switch and charge optimizer
package rail_pkg;

    // ******************************************************
    // widths
    // ******************************************************
    localparam int LEVEL_W      = 4;
    localparam int PROF_W       = 6;
    localparam int MARGIN_W     = 2;
    localparam int PROF_COUNT   = 64;

    // ******************************************************
    // reset values
    // ******************************************************
    // regulated level code used for 3.0 v; code mapping is analog side
    localparam logic [LEVEL_W-1:0]  VSET_RESET   = 4'h6;
    localparam logic [PROF_W-1:0]   PROF_RESET   = 6'h01;
    localparam logic [MARGIN_W-1:0] MARGIN_RESET = 2'h3;
    localparam logic                HIZ_RESET    = 1'b0;
    localparam logic [LEVEL_W-1:0]  FIX_RESET    = 4'hf;

    // ******************************************************
    // target levels
    // ******************************************************
    localparam logic [LEVEL_W-1:0]  LEVEL_MIN    = 4'h0;
    localparam logic [LEVEL_W-1:0]  CEIL_HIGH    = 4'hf;
    localparam logic [LEVEL_W-1:0]  CEIL_LOW     = 4'hb;
    // deficit at or beyond which the learned target climbs two steps
    localparam logic [LEVEL_W-1:0]  DEEP_DEFICIT = 4'h2;
    localparam logic [LEVEL_W-1:0]  STEP_ONE     = 4'h1;
    localparam logic [LEVEL_W-1:0]  STEP_TWO     = 4'h2;
    localparam logic [PROF_W-1:0]   PROF_OFF     = 6'h00;

    // ******************************************************
    // operating states
    // ******************************************************
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_CHARGE  = 2'b01,
        ST_ACTIVE  = 2'b10
    } op_state_t;

endpackage

// [rtl/rail_switch_charge_optimizer.sv]
// rail routing, regulated level and adaptive charge target control
// Notes on behaviour
// R1 - standby and charge: permanent supply output tied to battery input
// R2 - active: high-current output regulated at vset, permanent output tied to it
// R3 - high-z select resets to zero; then high-current output follows battery off-active
// R4 - high-z select set: high-current output undriven in standby and charge
// R5 - output level field sets active regulation, defaults to the 3.0 v code
// R6 - output level may change during active without leaving active
// R7 - up to 63 learned profiles, each with its own hidden target
// R8 - profile zero disables learning and charges to the fixed target
// R9 - after reset profile one and margin code 11b are selected
// R10 - host changes profile and margin only through write strobes
// R11 - margin codes map to the four lowest learned levels
// R12 - new learning starts at the ceiling, level 15 when ceiling bit set
// R13 - on-demand start charges to target then enters active automatically
// R14 - capacitor above margin at active end: learned target down one
// R15 - capacitor below margin at active end: learned target up one or more
// R16 - profile reset bit restarts learning of selected profile unless a learning write lands in the same cycle; also at power-on
// R17 - each profile keeps its own learned target across profile switches
// R18 - charge target never exceeds the ceiling selected by the ceiling bit
// R19 - equal to margin leaves target unchanged; targets stay within floor and ceiling
module rail_switch_charge_optimizer
    import rail_pkg::*;
(
    input  wire logic               CLOCK,
    input  wire logic               RST_N,
    input  wire logic               CE,
    input  wire logic               ON_DEMAND,
    input  wire logic               FORCE_ACTIVE,
    input  wire logic               START_PIN,
    input  wire logic [LEVEL_W-1:0] CAP_LEVEL,
    input  wire logic               VSET_WR,
    input  wire logic [LEVEL_W-1:0] VSET_DATA,
    input  wire logic               HIZ_WR,
    input  wire logic               HIZ_DATA,
    input  wire logic               PROF_WR,
    input  wire logic [PROF_W-1:0]  PROF_DATA,
    input  wire logic               PROF_RESTART,
    input  wire logic               MARGIN_WR,
    input  wire logic [MARGIN_W-1:0] MARGIN_DATA,
    input  wire logic               FIX_WR,
    input  wire logic [LEVEL_W-1:0] FIX_DATA,
    input  wire logic               CEIL_SEL,
    output logic      [1:0]         STATE,
    output logic                    PERM_FROM_BATTERY,
    output logic                    PERM_FROM_HC,
    output logic                    HC_FROM_BATTERY,
    output logic                    HC_FROM_REG,
    output logic                    HC_HIZ,
    output logic      [LEVEL_W-1:0] REG_LEVEL,
    output logic                    CHARGE_EN,
    output logic      [LEVEL_W-1:0] CHARGE_TARGET,
    output logic      [LEVEL_W-1:0] VSET,
    output logic                    HIZ_SEL,
    output logic      [PROF_W-1:0]  PROF,
    output logic      [MARGIN_W-1:0] MARGIN
);

    // ******************************************************
    // functions
    // ******************************************************
    function automatic logic [LEVEL_W-1:0] ceil_of(input logic sel);
        ceil_of = sel ? CEIL_HIGH : CEIL_LOW;
    endfunction

    function automatic logic [LEVEL_W-1:0] min_level(input logic [LEVEL_W-1:0] a,
                                                      input logic [LEVEL_W-1:0] b);
        min_level = (a < b) ? a : b;
    endfunction

    // ******************************************************
    // input synchronisers
    // ******************************************************
    logic               start_meta;
    logic               start_sync;
    logic [LEVEL_W-1:0] cap_meta;
    logic [LEVEL_W-1:0] cap_sync;

    // cap code comes from a slow analog comparator ladder, one step at a time
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            cap_meta   <= LEVEL_MIN;
            cap_sync   <= LEVEL_MIN;
        end else if (CE) begin
            start_meta <= START_PIN;
            start_sync <= start_meta;
            cap_meta   <= CAP_LEVEL;
            cap_sync   <= cap_meta;
        end
    end

    // ******************************************************
    // configuration fields
    // ******************************************************
    logic [LEVEL_W-1:0]  vset;
    logic                hiz_sel;
    logic [PROF_W-1:0]   prof;
    logic [MARGIN_W-1:0] margin;
    logic [LEVEL_W-1:0]  fix_level;

    // R5 R6 level default, live update
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            vset <= VSET_RESET;
        end else if (CE && VSET_WR) begin
            vset <= VSET_DATA;
        end
    end

    // R3 high-z clear at reset
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            hiz_sel <= HIZ_RESET;
        end else if (CE && HIZ_WR) begin
            hiz_sel <= HIZ_DATA;
        end
    end

    // R9 R10 profile one, strobed writes
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            prof <= PROF_RESET;
        end else if (CE && PROF_WR) begin
            prof <= PROF_DATA;
        end
    end

    // R9 R10 margin 11b, strobed writes
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            margin <= MARGIN_RESET;
        end else if (CE && MARGIN_WR) begin
            margin <= MARGIN_DATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            fix_level <= FIX_RESET;
        end else if (CE && FIX_WR) begin
            fix_level <= FIX_DATA;
        end
    end

    // ******************************************************
    // target selection
    // ******************************************************
    wire                opt_on;
    wire [LEVEL_W-1:0]  ceiling;
    wire [LEVEL_W-1:0]  stored_level;
    wire                stored_valid;
    wire [LEVEL_W-1:0]  learned;
    wire [LEVEL_W-1:0]  raw_target;
    wire [LEVEL_W-1:0]  target;
    wire [LEVEL_W-1:0]  threshold;

    // R8 profile zero uses fixed
    assign opt_on     = (prof != PROF_OFF);
    assign ceiling    = ceil_of(CEIL_SEL);
    // R12 fresh profile starts at ceiling
    assign learned    = stored_valid ? stored_level : ceiling;
    assign raw_target = opt_on ? learned : fix_level;
    // R18 ceiling clamp
    assign target     = min_level(raw_target, ceiling);
    // R11 margin maps to lowest levels
    assign threshold  = LEVEL_MIN + LEVEL_W'(margin);

    // ******************************************************
    // learning step at end of active
    // ******************************************************
    wire               cap_above;
    wire               cap_below;
    wire [LEVEL_W-1:0] deficit;
    wire [LEVEL_W-1:0] up_step;
    wire [LEVEL_W-1:0] room_up;
    wire [LEVEL_W-1:0] next_up;
    wire [LEVEL_W-1:0] next_down;
    wire [LEVEL_W-1:0] next_learned;

    assign cap_above = cap_sync > threshold;
    assign cap_below = cap_sync < threshold;
    assign deficit   = threshold - cap_sync;
    // R15 deep shortfall climbs two
    assign up_step   = (deficit >= DEEP_DEFICIT) ? STEP_TWO : STEP_ONE;
    // R19 upward move stops at ceiling
    assign room_up   = (ceiling > learned) ? (ceiling - learned) : LEVEL_MIN;
    assign next_up   = learned + min_level(up_step, room_up);
    // R14 one step down, floor kept
    assign next_down = (learned > LEVEL_MIN) ? (learned - STEP_ONE) : LEVEL_MIN;
    // R19 equal leaves unchanged
    assign next_learned = cap_above ? next_down :
                          cap_below ? next_up   : learned;

    // ******************************************************
    // operating state machine
    // ******************************************************
    op_state_t state;
    op_state_t next_state;
    wire       demand;
    wire       charged;
    wire       active_end;
    wire       learn_wr;

    // a start pin cycle lasts while the pin stays high
    assign demand     = ON_DEMAND | start_sync;
    assign charged    = cap_sync >= target;
    assign active_end = (state == ST_ACTIVE) && !demand;
    assign learn_wr   = active_end && opt_on;

    always_comb begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (demand) begin
                    next_state = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                // R13 auto enter active
                if (!demand) begin
                    next_state = ST_STANDBY;
                end else if (charged || FORCE_ACTIVE) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!demand) begin
                    next_state = ST_STANDBY;
                end
            end
            default: begin
                next_state = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state <= ST_STANDBY;
        end else if (CE) begin
            state <= next_state;
        end
    end

    // ******************************************************
    // learned target storage
    // ******************************************************
    // R7 R17 per-profile store; R16 restart clears entry
    profile_store u_store (
        .clock    (CLOCK),
        .rst_n    (RST_N),
        .ce       (CE),
        .rd_prof  (prof),
        .rd_level (stored_level),
        .rd_valid (stored_valid),
        .wr_en    (learn_wr),
        .wr_prof  (prof),
        .wr_level (next_learned),
        .clr_en   (PROF_RESTART),
        .clr_prof (prof)
    );

    // ******************************************************
    // rail switches and registered outputs
    // ******************************************************
    wire next_active;
    wire next_offactive;
    wire next_perm_bat;
    wire next_perm_hc;
    wire next_hc_bat;
    wire next_hc_reg;
    wire next_hc_hiz;
    wire next_charge_en;

    assign next_active    = (next_state == ST_ACTIVE);
    assign next_offactive = !next_active;
    // R1 permanent from battery
    assign next_perm_bat  = next_offactive;
    // R2 permanent and high-current from regulator
    assign next_perm_hc   = next_active;
    assign next_hc_reg    = next_active;
    // R3 battery feed off-active
    assign next_hc_bat    = next_offactive && !hiz_sel;
    // R4 high-z off-active
    assign next_hc_hiz    = next_offactive && hiz_sel;
    assign next_charge_en = (next_state == ST_CHARGE);

    // outputs follow next state so the rails switch on the state edge
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            STATE             <= ST_STANDBY;
            PERM_FROM_BATTERY <= 1'b1;
            PERM_FROM_HC      <= 1'b0;
        end else if (CE) begin
            STATE             <= next_state;
            PERM_FROM_BATTERY <= next_perm_bat;
            PERM_FROM_HC      <= next_perm_hc;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            HC_FROM_BATTERY <= 1'b1;
            HC_FROM_REG     <= 1'b0;
            HC_HIZ          <= 1'b0;
        end else if (CE) begin
            HC_FROM_BATTERY <= next_hc_bat;
            HC_FROM_REG     <= next_hc_reg;
            HC_HIZ          <= next_hc_hiz;
        end
    end

    // R6 level tracks vset live
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            REG_LEVEL <= VSET_RESET;
        end else if (CE) begin
            REG_LEVEL <= vset;
        end
    end

    // R13 R18 charge enable and clamped target
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CHARGE_EN     <= 1'b0;
            CHARGE_TARGET <= FIX_RESET;
        end else if (CE) begin
            CHARGE_EN     <= next_charge_en;
            CHARGE_TARGET <= target;
        end
    end

    // readback of configuration fields
    assign VSET    = vset;
    assign HIZ_SEL = hiz_sel;
    assign PROF    = prof;
    assign MARGIN  = margin;

endmodule // rail_switch_charge_optimizer
